/* File: bench/lsg_monitor.sv */
module lsg_monitor #(
   parameter int SEQ_CLKS = 2  // clock rises in a mode sequence
)(
   input wire logic ref_clk_i,       // system clock
   input wire logic reset_n_i,       // async reset, low
   input wire logic serial_in,       // data pin
   input wire logic sclk,            // serial clock pin
   input wire logic latch_strobe,    // strobe pin
   input wire logic output_blank_n,  // blank pin
   input wire logic serial_out       // cascade pin
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   logic       sclk_q;
   logic [7:0] mdl_q;
   logic [3:0] seq_cnt_q;
   logic       sclk_rise;
   logic       mdl_msb;
   assign sclk_rise = sclk & ~sclk_q;
   assign mdl_msb   = mdl_q[7];

   // reference shift chain and rises counted per strobe pulse
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sclk_q    <= 1'b0;
         mdl_q     <= 8'h00;
         seq_cnt_q <= 4'h0;
      end
      else
      begin
         sclk_q <= sclk;
         if (sclk_rise)
            mdl_q <= {mdl_q[6:0], serial_in};
         if (!latch_strobe)
            seq_cnt_q <= 4'h0;
         else if (sclk_rise)
            seq_cnt_q <= seq_cnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_sclk_pulse;
      sclk [*2] ##1 !sclk;
   endsequence
   // six cycles clears the driver's pin filter but not the next rise
   sequence s_sdo_settled;
      ##6 (serial_out == $past(mdl_msb, 5));
   endsequence
   property p_sclk_width;
      $rose(sclk) |-> s_sclk_pulse;
   endproperty
   property p_sdi_hold;
      $changed(serial_in) |-> !sclk;
   endproperty
   property p_sdo_order;
      $rose(sclk) |-> s_sdo_settled;
   endproperty
   property p_strobe_width;
      $rose(latch_strobe) |-> latch_strobe [*3];
   endproperty
   property p_strobe_rise;
      $rose(latch_strobe) |-> !sclk;
   endproperty
   property p_strobe_fall;
      $fell(latch_strobe) |-> !sclk;
   endproperty
   property p_seq_count;
      $fell(latch_strobe) |->
         (seq_cnt_q == 4'h0 || seq_cnt_q == 4'(SEQ_CLKS));
   endproperty
   property p_reset_idle;
      $rose(reset_n_i) |-> output_blank_n && !sclk && !latch_strobe;
   endproperty

   a_sclk_width: assert property (p_sclk_width)
      else $error("serial clock high time wrong");
   a_sdi_hold: assert property (p_sdi_hold)
      else $error("serial data moved while clock high");
   a_sdo_order: assert property (p_sdo_order)
      else $error("cascade bit differs from eighth stage");
   a_strobe_width: assert property (p_strobe_width)
      else $error("strobe pulse too short");
   a_strobe_rise: assert property (p_strobe_rise)
      else $error("strobe rose with clock high");
   a_strobe_fall: assert property (p_strobe_fall)
      else $error("strobe fell with clock high");
   a_seq_count: assert property (p_seq_count)
      else $error("wrong clock count inside strobe");
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins not idle after reset");
endmodule

/* File: bench/lsg_test.sv */
`include "lsg_defs.svh"
module lsg_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic       ref_clk = 1'b0;
   logic       reset_n;
   logic       start;
   logic [1:0] op;
   logic [7:0] data;
   logic       blank_n;
   logic       done;
   logic       busy;
   logic       gain_mode;
   logic [7:0] sinks;
   logic [7:0] latch;
   logic [7:0] gain;
   logic [7:0] held;
   int         err_total = 0;
   int         n_compared = 0;
   int         cycles = 0;

   lsg_if bus ();
   lsg_ctrl lsg_ctrl_i (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
      .link(bus), .start_i(start), .op_i(op), .data_i(data),
      .blank_n_i(blank_n), .busy_o(busy), .done_o(done));
   lsg_driver lsg_driver_i (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
      .link(bus), .sinks_on_o(sinks), .latch_o(latch), .gain_o(gain),
      .gain_mode_o(gain_mode));
   lsg_monitor #(.SEQ_CLKS(`LSG_SEQ_CLKS)) lsg_monitor_i (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n),
      .serial_in(bus.serial_in), .sclk(bus.sclk),
      .latch_strobe(bus.latch_strobe),
      .output_blank_n(bus.output_blank_n), .serial_out(bus.serial_out));

   always #25 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one controller operation; display words check the held latch midway
   task automatic run_op(input logic [1:0] code, input logic [7:0] word,
                         input logic [7:0] hold);
      int n;
      @(posedge ref_clk);
      start <= 1'b1;
      op    <= code;
      data  <= word;
      @(posedge ref_clk);
      start <= 1'b0;
      @(negedge ref_clk);
      chk({7'h0, busy}, 8'h01);
      // a word is still shifting here, so the display must not move
      if (code == 2'd0)
      begin
         repeat (11) @(negedge ref_clk);
         chk(latch, hold);
      end
      for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge ref_clk);
      // a missing done pulse counts as a mismatch
      chk({6'h0, busy, done}, 8'h01);
      // pins pass a synchroniser, so let the driver settle
      repeat (8) @(negedge ref_clk);
   endtask

   task automatic set_blank(input logic lvl);
      @(posedge ref_clk);
      blank_n <= lvl;
      repeat (10) @(negedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_n = 1'b0;
      start   = 1'b0;
      op      = 2'd0;
      data    = 8'h00;
      blank_n = 1'b1;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      chk(gain, 8'h40);
      chk({7'h0, gain_mode}, 8'h00);
      set_blank(1'b0);
      run_op(2'd0, 8'ha5, 8'h00);
      chk(latch, 8'ha5);
      chk(sinks, 8'ha5);
      run_op(2'd0, 8'h3c, 8'ha5);
      chk(latch, 8'h3c);
      set_blank(1'b1);
      chk(sinks, 8'h00);
      set_blank(1'b0);
      run_op(2'd1, 8'h00, 8'h00);
      chk({7'h0, gain_mode}, 8'h01);
      held = latch;
      // both ends of the code range, then a middle value
      run_op(2'd3, 8'h7f, held);
      chk(gain, 8'h7f);
      run_op(2'd3, 8'h00, held);
      chk(gain, 8'h00);
      run_op(2'd3, 8'h15, held);
      chk(gain, 8'h15);
      chk(latch, held);
      chk(sinks, held);
      set_blank(1'b1);
      chk(sinks, 8'h00);
      set_blank(1'b0);
      run_op(2'd2, 8'h00, held);
      chk({7'h0, gain_mode}, 8'h00);
      chk(gain, 8'h15);
      run_op(2'd0, 8'h81, held);
      chk(latch, 8'h81);
      chk(gain, 8'h15);
      // second reset in mid-run restores the default gain
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      chk(gain, 8'h40);
      report_and_stop;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         report_and_stop;
      end
   end
endmodule

/* File: inc/lsg_defs.svh */
`ifndef LSG_DEFS_SVH
`define LSG_DEFS_SVH

`define LSG_CHANNELS     8
`define LSG_GAIN_BITS    7
`define LSG_CFG_BITS     8
`define LSG_SYNC_STAGES  3
`define LSG_SCLK_DIV     2
`define LSG_SEQ_CLKS     2
`define LSG_GAIN_RESET   8'h40
`define LSG_SR_RESET     8'h00

`endif

/* File: inc/lsg_if.sv */
interface lsg_if;
   logic serial_in;
   logic sclk;
   logic latch_strobe;
   logic output_blank_n;
   logic serial_out;

   modport ctrl (output serial_in, output sclk, output latch_strobe,
                 output output_blank_n, input serial_out);
   modport drv  (input serial_in, input sclk, input latch_strobe,
                 input output_blank_n, output serial_out);
endinterface

/* File: inc/lsg_pkg.sv */
package lsg_pkg;
   typedef enum logic [1:0]
   {
      LSG_NORMAL = 2'b00,
      LSG_GAIN   = 2'b01
   } lsg_mode_e;

   typedef enum logic [2:0]
   {
      LSG_H_IDLE  = 3'b000,
      LSG_H_SEQ   = 3'b001,
      LSG_H_SHIFT = 3'b010,
      LSG_H_STRB  = 3'b011,
      LSG_H_DONE  = 3'b100
   } lsg_host_st_e;
endpackage

/* File: rtl/lsg_ctrl.sv */
`include "lsg_defs.svh"
module lsg_ctrl #(
   parameter int CH       = `LSG_CHANNELS,
   parameter int SEQ_CLKS = `LSG_SEQ_CLKS,
   parameter int DIV      = `LSG_SCLK_DIV   // half-period in ref cycles
)(
   input  wire logic          ref_clk_i,    // system clock
   input  wire logic          reset_n_i,    // async reset, low
   lsg_if.ctrl                link,         // pins to driver
   input  wire logic          start_i,      // pulse: begin operation
   input  wire logic [1:0]    op_i,         // 0 data,1 enter,2 exit,3 gain
   input  wire logic [CH-1:0] data_i,       // word to shift
   input  wire logic          blank_n_i,    // display blank level
   output logic               busy_o,       // operation running
   output logic               done_o        // pulse: operation done
);
   // serial clock = ref/(2*DIV): 5 MHz default, under 25 MHz
   lsg_pkg::lsg_host_st_e st_q;
   logic [7:0]    tmr_q;
   logic [3:0]    cnt_q;
   logic [CH-1:0] sh_q;
   logic [1:0]    op_q;
   logic          sclk_q, le_q, oe_q;

   logic tick;
   assign tick = (tmr_q == 8'(DIV - 1));

   // half-period timer
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         tmr_q <= '0;
      else if (st_q == lsg_pkg::LSG_H_IDLE || tick)
         tmr_q <= '0;
      else
         tmr_q <= tmr_q + 8'h1;
   end

   // sequencer: SEQ makes entry/exit pattern, SHIFT sends a word
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q   <= lsg_pkg::LSG_H_IDLE;
         cnt_q  <= '0;
         sh_q   <= '0;
         op_q   <= '0;
         sclk_q <= 1'b0;
         le_q   <= 1'b0;
         oe_q   <= 1'b1;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         case (st_q)
            lsg_pkg::LSG_H_IDLE:
            begin
               oe_q <= blank_n_i;
               if (start_i)
               begin
                  op_q  <= op_i;
                  sh_q  <= data_i;
                  cnt_q <= '0;
                  if (op_i == 2'd1 || op_i == 2'd2)
                  begin
                     oe_q  <= (op_i == 2'd1);
                     le_q  <= 1'b1;
                     st_q  <= lsg_pkg::LSG_H_SEQ;
                  end
                  else
                     st_q <= lsg_pkg::LSG_H_SHIFT;
               end
            end
            lsg_pkg::LSG_H_SEQ:
               if (tick)
               begin
                  sclk_q <= ~sclk_q;
                  if (sclk_q)
                  begin
                     if (cnt_q == 4'(SEQ_CLKS - 1))
                        st_q <= lsg_pkg::LSG_H_DONE;
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            lsg_pkg::LSG_H_SHIFT:
               if (tick)
               begin
                  sclk_q <= ~sclk_q;
                  if (sclk_q)
                  begin
                     sh_q <= {sh_q[CH-2:0], 1'b0};
                     if (cnt_q == 4'(CH - 1))
                     begin
                        le_q <= 1'b1;
                        st_q <= lsg_pkg::LSG_H_STRB;
                     end
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            lsg_pkg::LSG_H_STRB:
               if (tick)
                  st_q <= lsg_pkg::LSG_H_DONE;
            lsg_pkg::LSG_H_DONE:
               if (tick)
               begin
                  le_q   <= 1'b0;
                  done_o <= 1'b1;
                  st_q   <= lsg_pkg::LSG_H_IDLE;
               end
            default:
               st_q <= lsg_pkg::LSG_H_IDLE;
         endcase
      end
   end

   // serial data bit: moves on the clock fall, half a period ahead of
   // the rise that samples it, so it never races the clock through
   // the driver's pin filters
   logic din_q;
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         din_q <= 1'b0;
      else if (st_q == lsg_pkg::LSG_H_IDLE && start_i)
         din_q <= data_i[CH-1];
      else if (st_q == lsg_pkg::LSG_H_SHIFT && tick && sclk_q)
         din_q <= sh_q[CH-2];
   end

   assign link.serial_in      = din_q;
   assign link.sclk           = sclk_q;
   assign link.latch_strobe   = le_q;
   assign link.output_blank_n = oe_q;
   assign busy_o = (st_q != lsg_pkg::LSG_H_IDLE);
endmodule

/* File: rtl/lsg_driver.sv */
`include "lsg_defs.svh"
module lsg_driver #(
   parameter int CH       = `LSG_CHANNELS,
   parameter int SEQ_CLKS = `LSG_SEQ_CLKS  // clocks counted for a sequence
)(
   input  wire logic          ref_clk_i,    // system clock
   input  wire logic          reset_n_i,    // async reset, low
   lsg_if.drv                 link,         // pins from controller
   output logic [CH-1:0]      sinks_on_o,   // channel sink on, high
   output logic [CH-1:0]      latch_o,      // display latch contents
   output logic [`LSG_CFG_BITS-1:0] gain_o, // gain setting latch
   output logic               gain_mode_o   // high in gain mode
);
   ////////////////////////////////////////////////////////////////////
   // three-stage synchronisers; change valid when stages 2 and 3 agree
   logic [`LSG_SYNC_STAGES-1:0] s_clk_q, s_din_q, s_le_q, s_oe_q;
   logic clk_f_q, din_f_q, le_f_q, oe_f_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_clk_q <= '0;
         s_din_q <= '0;
         s_le_q  <= '0;
         s_oe_q  <= '1;
      end
      else
      begin
         s_clk_q <= {s_clk_q[1:0], link.sclk};
         s_din_q <= {s_din_q[1:0], link.serial_in};
         s_le_q  <= {s_le_q[1:0],  link.latch_strobe};
         s_oe_q  <= {s_oe_q[1:0],  link.output_blank_n};
      end
   end

   // filtered levels: take a new value only when stages agree
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         clk_f_q <= 1'b0;
         din_f_q <= 1'b0;
         le_f_q  <= 1'b0;
         oe_f_q  <= 1'b1;
      end
      else
      begin
         if (s_clk_q[1] == s_clk_q[2]) clk_f_q <= s_clk_q[2];
         if (s_din_q[1] == s_din_q[2]) din_f_q <= s_din_q[2];
         if (s_le_q[1] == s_le_q[2])   le_f_q  <= s_le_q[2];
         if (s_oe_q[1] == s_oe_q[2])   oe_f_q  <= s_oe_q[2];
      end
   end

   // data lags clock filter by one stage, so sample current data
   logic clk_rise, le_rise, le_fall;
   logic clk_d;
   assign clk_d   = (s_clk_q[1] == s_clk_q[2]) ? s_clk_q[2] : clk_f_q;
   assign clk_rise = clk_d & ~clk_f_q;
   logic le_d;
   assign le_d    = (s_le_q[1] == s_le_q[2]) ? s_le_q[2] : le_f_q;
   assign le_rise = le_d & ~le_f_q;
   assign le_fall = ~le_d & le_f_q;

   ////////////////////////////////////////////////////////////////////
   // shift register, runs in every mode
   logic [CH-1:0] shift_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         shift_q <= CH'(`LSG_SR_RESET);
      else if (clk_rise)
         shift_q <= {shift_q[CH-2:0], din_f_q};
   end

   assign link.serial_out = shift_q[CH-1];

   ////////////////////////////////////////////////////////////////////
   // mode sequencer: entry is strobe pulse with blank high and
   // SEQ_CLKS clock rises while strobe is high; exit the same with
   // blank low. plain strobes never carry clock edges in normal use,
   // which keeps the legacy protocol safe.
   lsg_pkg::lsg_mode_e mode_q;
   logic [3:0]         seq_cnt_q;
   logic               seq_blank_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         seq_cnt_q <= '0;
      else if (le_rise)
         seq_cnt_q <= '0;
      else if (le_f_q && clk_rise && seq_cnt_q != 4'hf)
         seq_cnt_q <= seq_cnt_q + 4'h1;
   end

   // blank level taken at clock rises inside the strobe; a blank that
   // moved together with the strobe has cleared its filter by then
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         seq_blank_q <= 1'b0;
      else if (le_f_q && clk_rise)
         seq_blank_q <= oe_f_q;
   end

   logic seq_hit;
   assign seq_hit = le_fall && (seq_cnt_q == 4'(SEQ_CLKS));

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         mode_q <= lsg_pkg::LSG_NORMAL;
      else
      begin
         case (mode_q)
            lsg_pkg::LSG_NORMAL:
               if (seq_hit && seq_blank_q)
                  mode_q <= lsg_pkg::LSG_GAIN;
            lsg_pkg::LSG_GAIN:
               if (seq_hit && !seq_blank_q)
                  mode_q <= lsg_pkg::LSG_NORMAL;
            default:
               mode_q <= lsg_pkg::LSG_NORMAL;
         endcase
      end
   end

   assign gain_mode_o = (mode_q == lsg_pkg::LSG_GAIN);

   ////////////////////////////////////////////////////////////////////
   // display latch: transparent while strobe high, normal mode only
   logic [CH-1:0] latch_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         latch_q <= '0;
      else if (mode_q == lsg_pkg::LSG_NORMAL && le_f_q)
         latch_q <= shift_q;
      // low strobe or gain mode: hold
   end

   assign latch_o = latch_q;

   ////////////////////////////////////////////////////////////////////
   // gain latch: strobe pulse end in gain mode loads shift contents;
   // the sequence pulse itself is excluded so exit keeps the code
   logic [`LSG_CFG_BITS-1:0] gain_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         gain_q <= `LSG_GAIN_RESET;
      else if (gain_mode_o && le_fall && !seq_hit)
         gain_q <= shift_q[`LSG_CFG_BITS-1:0];
   end

   // low 7 bits step the 0.5..2 gain in 128 steps
   assign gain_o = gain_q;

   ////////////////////////////////////////////////////////////////////
   // blanking identical in both modes; registered output
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         sinks_on_o <= '0;
      else
         sinks_on_o <= oe_f_q ? '0 : latch_q;
   end
endmodule
